/* logic/smc_defs.vh */
// Purpose: constants for the sleep-mode controller
// Assumes: 20 MHz system clock
// Notes:   mode codes, field positions, reset values, timing counts
`ifndef SMC_DEFS_VH
`define SMC_DEFS_VH

// ***********************************************
// mode select encodings
// ***********************************************
`define SMC_MODE_IDLE    3'h0
`define SMC_MODE_NOISE   3'h1
`define SMC_MODE_PDOWN   3'h2
`define SMC_MODE_PSAVE   3'h3
`define SMC_MODE_RSVD4   3'h4
`define SMC_MODE_RSVD5   3'h5
`define SMC_MODE_STBY    3'h6
`define SMC_MODE_XSTBY   3'h7

// ***********************************************
// control register fields and reset values
// ***********************************************
`define SMC_BOSLEEP_BIT  6
`define SMC_BOSLEEP_RST  1'h0
`define SMC_MODE_RST     3'h0
`define SMC_ARM_RST      1'h0

// ***********************************************
// timing
// ***********************************************
`define SMC_CLK_MHZ      20
`define SMC_HALT_CYC     4
`define SMC_STBY_CYC     6
`define SMC_BOD_WAKE_US  60
`define SMC_BOD_WAKE_CYC (`SMC_BOD_WAKE_US * `SMC_CLK_MHZ)

`endif

/* logic/smc_sleep_ctrl.v */
// Purpose: sleep-mode controller: mode entry, clock gating, wake-up
// Assumes: all inputs synchronous to clock; one clock domain
// Notes:   start-up delay comes in as a cycle count from the fuse logic
`timescale 1ns/10ps
`include "smc_defs.vh"

// Operation
// - sleep needs arm bit plus sleep instruction
// - mode 000 idle stops cpu, flash clocks
// - mode 001 also stops io clock
// - mode 010 stops oscillator and all clocks
// - halt four cycles past start-up on wake
// - register file and sram kept through sleep
// - reset during sleep wakes to reset vector
// - power-down wake sources are restricted
// - noise mode adds adc, timer2, store-ready wake
// - external irqs wake deep modes level only
// - timer2 runs in sleep only when asynchronous; idle keeps it running and wakes on it either way
// - adc conversion starts entering idle or noise
// - brown-out-sleep bit 6, reset zero
// - detector off after entry, on at wake
// - wake extended to 60 us after detector off
// - brown-out-sleep write needs timed enable
// - detector disable only in deep modes
// - wake level must last through start-up
// - power-down wake delay equals reset time-out
// - mode 011 power-save keeps timer2 running
// - mode 110 standby keeps oscillator when crystal selected, six cycles
// - mode 111 extended standby, six cycles
module smc_sleep_ctrl
#(
  parameter STARTUP_W = 16,
  parameter BODWAKE   = `SMC_BOD_WAKE_CYC
)
(
  // clock and reset
  input  wire                 clock,
  input  wire                 rstn,
  // core side
  input  wire                 sleepExec,
  input  wire                 sleepArmBit,
  input  wire [2:0]           sleepModeSelect,
  input  wire                 boSleepWrite,
  input  wire                 boSleepWrData,
  input  wire                 boSleepWrEnable,
  input  wire                 xtalSelected,
  input  wire [STARTUP_W-1:0] startupCycles,
  input  wire                 sleepResetReq,
  // wake sources
  input  wire                 wakeResetEvt,
  input  wire                 wakeTimeoutSup,
  input  wire                 wakeTwoWireMatch,
  input  wire                 wakeExtIrq,
  input  wire                 extIrqIsLevel,
  input  wire                 wakePinChange,
  input  wire                 wakeTimer2,
  input  wire                 timer2Async,
  input  wire                 wakeAdcDone,
  input  wire                 wakeStoreReady,
  input  wire                 wakeOtherIo,
  input  wire                 adcEnabled,
  // clock generator and detector side
  output reg                  cpuClkEn,
  output reg                  flashClkEn,
  output reg                  ioClkEn,
  output reg                  adcClkEn,
  output reg                  asyClkEn,
  output reg                  oscEn,
  output reg                  timerOscEn,
  output reg                  brownoutEn,
  output reg                  adcStartPulse,
  output reg                  coreHalt,
  output reg                  takeIrq,
  output reg                  resetVector,
  output reg                  asleep,
  output reg                  boSleepBit
);

// ***********************************************
// state
// ***********************************************
localparam ST_RUN   = 2'h0;
localparam ST_SLEEP = 2'h1;
localparam ST_WAKE  = 2'h2;

localparam CW = 12;
localparam [CW-1:0] HALT_C  = `SMC_HALT_CYC;
localparam [CW-1:0] STBY_C  = `SMC_STBY_CYC;
localparam [CW-1:0] BODW_C  = BODWAKE;

reg [1:0]           state_ff;
reg [1:0]           nxt_state;
reg [2:0]           mode_ff;
reg                 bodOff_ff;
reg                 viaReset_ff;
reg [STARTUP_W+CW-1:0] cnt_ff;
reg [STARTUP_W+CW-1:0] nxt_cnt;
reg                 deep;
reg                 wakeOk;
reg                 extOk;
reg                 t2Ok;
reg [STARTUP_W+CW-1:0] wakeLen;
reg [STARTUP_W+CW-1:0] baseLen;
reg                 planIo;
reg                 planAdc;
reg                 planAsy;
reg                 planOsc;
reg                 planTosc;
reg                 planBoOff;
reg                 planAdcGo;

wire modeValid = (sleepModeSelect != `SMC_MODE_RSVD4) &&
                 (sleepModeSelect != `SMC_MODE_RSVD5);
wire enter = sleepExec && sleepArmBit && modeValid;

// ***********************************************
// per-mode clock plan
// ***********************************************
// one row per mode; a one keeps that clock running in sleep, planBoOff turns the detector off, planAdcGo starts the adc
always @*
begin
  planIo    = 1'b0;
  planAdc   = 1'b0;
  planAsy   = 1'b0;
  planOsc   = 1'b0;
  planTosc  = 1'b0;
  planBoOff = 1'b0;
  planAdcGo = 1'b0;
  case (sleepModeSelect)
    `SMC_MODE_IDLE:
    begin
      planIo    = 1'b1;
      planAdc   = 1'b1;
      planAsy   = 1'b1;
      planOsc   = 1'b1;
      planTosc  = timer2Async;
      planAdcGo = adcEnabled;
    end
    `SMC_MODE_NOISE:
    begin
      planAdc   = 1'b1;
      planAsy   = 1'b1;
      planOsc   = 1'b1;
      planTosc  = timer2Async;
      planAdcGo = adcEnabled;
    end
    `SMC_MODE_PDOWN:
    begin
      planBoOff = boSleepBit;
    end
    `SMC_MODE_PSAVE:
    begin
      planAsy   = timer2Async;
      planTosc  = timer2Async;
      planBoOff = boSleepBit;
    end
    `SMC_MODE_STBY:
    begin
      planOsc   = xtalSelected;
      planBoOff = boSleepBit;
    end
    `SMC_MODE_XSTBY:
    begin
      planAsy   = timer2Async;
      planOsc   = xtalSelected;
      planTosc  = timer2Async;
      planBoOff = boSleepBit;
    end
    default:
      planBoOff = 1'b0;
  endcase
end

// ***********************************************
// brown-out-sleep control bit
// ***********************************************
// accepted only inside the timed enable window from the core
always @(posedge clock or negedge rstn)
begin
  if (!rstn)
    boSleepBit <= `SMC_BOSLEEP_RST;
  else if (boSleepWrite && boSleepWrEnable)
    boSleepBit <= boSleepWrData;
end

// ***********************************************
// wake qualification
// ***********************************************
always @*
begin
  deep  = (mode_ff != `SMC_MODE_IDLE);
  extOk = wakeExtIrq && (!deep || extIrqIsLevel);
  t2Ok  = wakeTimer2 && timer2Async;
  wakeOk = wakeResetEvt || wakeTimeoutSup || wakeTwoWireMatch ||
           extOk || wakePinChange;
  case (mode_ff)
    `SMC_MODE_IDLE:
      wakeOk = wakeOk || wakeTimer2 || wakeAdcDone ||
               wakeStoreReady || wakeOtherIo;
    `SMC_MODE_NOISE:
      wakeOk = wakeOk || t2Ok || wakeAdcDone ||
               wakeStoreReady;
    `SMC_MODE_PSAVE,
    `SMC_MODE_XSTBY:
      wakeOk = wakeOk || t2Ok;
    default:
      wakeOk = wakeOk;
  endcase
end

// ***********************************************
// wake length
// ***********************************************
// the oscillator survives standby only with the crystal selected, yet no fuse start-up is added either way
always @*
begin
  case (mode_ff)
    `SMC_MODE_STBY,
    `SMC_MODE_XSTBY:
      baseLen = {{STARTUP_W{1'b0}}, STBY_C};
    `SMC_MODE_IDLE,
    `SMC_MODE_NOISE:
      baseLen = {{STARTUP_W{1'b0}}, HALT_C};
    default:
      baseLen = {{CW{1'b0}}, startupCycles} +
                {{STARTUP_W{1'b0}}, HALT_C};
  endcase
  if (bodOff_ff && baseLen < {{STARTUP_W{1'b0}}, BODW_C})
    wakeLen = {{STARTUP_W{1'b0}}, BODW_C};
  else
    wakeLen = baseLen;
end

// ***********************************************
// sequencer
// ***********************************************
always @*
begin
  nxt_state = state_ff;
  nxt_cnt   = cnt_ff;
  case (state_ff)
    ST_RUN:
      if (enter)
        nxt_state = ST_SLEEP;
    ST_SLEEP:
      if (sleepResetReq || wakeOk)
      begin
        nxt_state = ST_WAKE;
        nxt_cnt   = wakeLen - 1'b1;
      end
    ST_WAKE:
      if (cnt_ff == {(STARTUP_W+CW){1'b0}})
        nxt_state = ST_RUN;
      else
        nxt_cnt = cnt_ff - 1'b1;
    default:
      nxt_state = ST_RUN;
  endcase
end

always @(posedge clock or negedge rstn)
begin
  if (!rstn)
  begin
    state_ff    <= ST_RUN;
    mode_ff     <= `SMC_MODE_RST;
    bodOff_ff   <= 1'b0;
    viaReset_ff <= 1'b0;
    cnt_ff      <= {(STARTUP_W+CW){1'b0}};
  end
  else
  begin
    state_ff <= nxt_state;
    cnt_ff   <= nxt_cnt;
    if (state_ff == ST_RUN && enter)
    begin
      mode_ff     <= sleepModeSelect;
      viaReset_ff <= 1'b0;
      bodOff_ff   <= planBoOff;
    end
    if (state_ff == ST_SLEEP && sleepResetReq)
      viaReset_ff <= 1'b1;
    if (state_ff == ST_WAKE && nxt_state == ST_RUN)
      bodOff_ff <= 1'b0;
  end
end

// ***********************************************
// outputs
// ***********************************************
// clocks only gated; storage never reset here, contents kept
always @(posedge clock or negedge rstn)
begin
  if (!rstn)
  begin
    cpuClkEn      <= 1'b1;
    flashClkEn    <= 1'b1;
    ioClkEn       <= 1'b1;
    adcClkEn      <= 1'b1;
    asyClkEn      <= 1'b1;
    oscEn         <= 1'b1;
    timerOscEn    <= 1'b1;
    brownoutEn    <= 1'b1;
    adcStartPulse <= 1'b0;
    coreHalt      <= 1'b0;
    takeIrq       <= 1'b0;
    resetVector   <= 1'b0;
    asleep        <= 1'b0;
  end
  else
  begin
    adcStartPulse <= 1'b0;
    takeIrq       <= 1'b0;
    resetVector   <= 1'b0;
    if (state_ff == ST_RUN && enter)
    begin
      asleep     <= 1'b1;
      coreHalt   <= 1'b1;
      cpuClkEn   <= 1'b0;
      flashClkEn <= 1'b0;
      ioClkEn    <= planIo;
      adcClkEn   <= planAdc;
      asyClkEn   <= planAsy;
      oscEn      <= planOsc;
      timerOscEn <= planTosc;
      brownoutEn <= !planBoOff;
      adcStartPulse <= planAdcGo;
    end
    else if (state_ff == ST_SLEEP && nxt_state == ST_WAKE)
    begin
      asleep     <= 1'b0;
      brownoutEn <= 1'b1;
      cpuClkEn   <= 1'b1;
      flashClkEn <= 1'b1;
      ioClkEn    <= 1'b1;
      adcClkEn   <= 1'b1;
      asyClkEn   <= 1'b1;
      oscEn      <= 1'b1;
      timerOscEn <= 1'b1;
    end
    else if (state_ff == ST_WAKE && nxt_state == ST_RUN)
    begin
      coreHalt <= 1'b0;
      // level gone before start-up end: wake without irq
      takeIrq  <= !viaReset_ff && wakeOk;
      resetVector <= viaReset_ff;
    end
  end
end

endmodule // smc_sleep_ctrl

/* testbench/smc_irq_model.sv */
// Purpose: interrupt-logic model holding a level wake request
// Assumes: one clock; request dropped once the core takes it
// Notes:   level held through start-up, else no irq follows
`timescale 1ns/10ps
module smc_irq_model
(
  input  wire clock,
  input  wire rstn,
  input  wire raise,
  input  wire taken,
  output reg  levelFf
);
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      levelFf <= 1'h0;
    else if (taken)
      levelFf <= 1'h0;
    else if (raise)
      levelFf <= 1'h1;
  end
endmodule // smc_irq_model

/* testbench/smc_sleep_props.sv */
// Purpose: port assertions for the sleep-mode controller
// Assumes: mode select held steady while asleep
// Notes:   bound into every smc_sleep_ctrl
`timescale 1ns/10ps
module smc_sleep_props
(
  input logic       clock, rstn, sleepExec, sleepArmBit,
  input logic [2:0] sleepModeSelect,
  input logic       boSleepWrite, boSleepWrData, boSleepWrEnable,
  input logic       adcEnabled, cpuClkEn, flashClkEn, ioClkEn, adcClkEn,
  input logic       oscEn, brownoutEn, adcStartPulse, coreHalt, takeIrq,
  input logic       asleep, resetVector, boSleepBit
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  a_arm_needed: assert property (
    !asleep && sleepExec && !sleepArmBit |=> !asleep) else $error("no arm");
  a_rsvd_noop: assert property (
    !asleep && sleepExec && sleepModeSelect[2:1] == 2'h2 |=> !asleep)
    else $error("reserved mode slept");
  a_idle_clocks: assert property (
    $rose(asleep) && $past(sleepModeSelect) == 3'h0 |-> !cpuClkEn
    && !flashClkEn && ioClkEn && adcClkEn && oscEn) else $error("idle");
  a_noise_clocks: assert property (
    $rose(asleep) && $past(sleepModeSelect) == 3'h1 |-> !cpuClkEn
    && !ioClkEn && adcClkEn) else $error("noise clocks");
  a_pdown_clocks: assert property (
    $rose(asleep) && $past(sleepModeSelect) == 3'h2 |-> !cpuClkEn
    && !ioClkEn && !adcClkEn && !oscEn) else $error("pdown clocks");
  a_bod_kept: assert property (
    $rose(asleep) && !$past(sleepModeSelect[1]) |-> brownoutEn)
    else $error("detector off in light mode");
  a_adc_start: assert property (
    $rose(asleep) && $past(sleepModeSelect[2:1]) == 2'h0
    && $past(adcEnabled) |-> adcStartPulse) else $error("no adc start");
  a_wake_restore: assert property (
    $fell(asleep) |-> cpuClkEn && oscEn && brownoutEn && coreHalt)
    else $error("wake restore");
  a_idle_halt: assert property (
    $fell(asleep) && sleepModeSelect == 3'h0 |-> coreHalt[*4] ##1 !coreHalt)
    else $error("halt length");
  a_irq_single: assert property (
    takeIrq |-> !coreHalt ##1 !takeIrq) else $error("irq pulse");
  a_bo_write: assert property (
    boSleepWrite && boSleepWrEnable |=> boSleepBit == $past(boSleepWrData))
    else $error("bo bit write");
  cover property ($fell(asleep));
  cover property (takeIrq);
  cover property (resetVector);
endmodule // smc_sleep_props
bind smc_sleep_ctrl smc_sleep_props u_props (.*);

/* testbench/testbench.sv */
// Purpose: directed bench for the sleep-mode controller
// Assumes: 20 MHz clock, short brown-out wake count
// Notes:   wake lengths expected from mode and start-up count
`timescale 1ns/10ps
module testbench;
  reg        clock, rstn, sleepExec, sleepArmBit, boSleepWrite;
  reg        boSleepWrData, boSleepWrEnable, xtalSelected, sleepResetReq;
  reg        wakeResetEvt, wakeTimeoutSup, wakeTwoWireMatch, extIrqIsLevel;
  reg        wakePinChange, wakeTimer2, timer2Async, wakeAdcDone, irqRaise;
  reg        wakeStoreReady, wakeOtherIo, adcEnabled;
  reg  [2:0] sleepModeSelect;
  reg [15:0] startupCycles, n;
  wire       wakeExtIrq, cpuClkEn, flashClkEn, ioClkEn, adcClkEn, asyClkEn;
  wire       oscEn, timerOscEn, brownoutEn, adcStartPulse, coreHalt, takeIrq;
  wire       resetVector, asleep, boSleepBit;
  integer    errCount, checkCount, m;
  smc_sleep_ctrl #(.STARTUP_W(16), .BODWAKE(20)) u_dut (.*);
  smc_irq_model u_irq (.clock(clock), .rstn(rstn), .raise(irqRaise),
    .taken(takeIrq | resetVector), .levelFf(wakeExtIrq));
  // ***********************************************
  // tasks
  // ***********************************************
  task chk(input [15:0] seen, input [15:0] exp);
  begin
    checkCount = checkCount + 1;
    if (seen !== exp)
    begin
      errCount = errCount + 1;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask
  task go_sleep(input [2:0] mode, input arm);
  begin
    @(posedge clock);
    sleepModeSelect <= mode;
    sleepArmBit <= arm;
    sleepExec <= 1'h1;
    @(posedge clock);
    sleepExec <= 1'h0;
    #1;
  end
  endtask
  task bo_write(input d);
  begin
    @(posedge clock);
    {boSleepWrite, boSleepWrData, boSleepWrEnable} <= {1'h1, d, 1'h1};
    @(posedge clock);
    boSleepWrite <= 1'h0;
    #1;
    chk(boSleepBit, d);
  end
  endtask
  // bounded: a stuck wake shows up as a wrong length, not a hang
  task wait_wake;
  begin
    n = 0;
    while (asleep === 1'h1 && n < 16'h0064)
    begin
      @(posedge clock);
      #1;
      n = n + 1;
    end
    n = 0;
    while (coreHalt === 1'h1 && n < 16'h0064)
    begin
      @(posedge clock);
      #1;
      n = n + 1;
    end
  end
  endtask
  task complete_run;
  begin
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  initial
  begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end
  initial
  begin
    #100000;
    errCount = errCount + 1;
    complete_run;
  end
  initial
  begin
    {sleepExec, sleepArmBit, boSleepWrite, boSleepWrData, boSleepWrEnable,
     xtalSelected, sleepResetReq, wakeResetEvt, wakeTimeoutSup,
     wakeTwoWireMatch, extIrqIsLevel, wakePinChange, wakeTimer2, timer2Async,
     wakeAdcDone, irqRaise, wakeStoreReady, wakeOtherIo} = 18'h0;
    {adcEnabled, rstn, errCount, checkCount} = 0;
    sleepModeSelect = 3'h0;
    startupCycles = 16'h000a;
    repeat (2) @(posedge clock);
    rstn <= 1'h1;
    #1;
    chk({cpuClkEn, oscEn, brownoutEn, asleep, boSleepBit}, 16'h1c);
    go_sleep(3'h2, 1'h0);
    chk(asleep, 1'h0);
    for (m = 4; m < 6; m = m + 1)
    begin
      go_sleep(m[2:0], 1'h1);
      chk({asleep, cpuClkEn}, 16'h1);
    end
    $display("test refusals done");
    adcEnabled <= 1'h1;
    go_sleep(3'h0, 1'h1);
    chk({asleep, cpuClkEn, ioClkEn, adcStartPulse}, 16'hb);
    @(posedge clock) wakeOtherIo <= 1'h1;
    wait_wake;
    chk(n, 16'h4);
    chk(takeIrq, 1'h1);
    @(posedge clock) wakeOtherIo <= 1'h0;
    $display("test idle done");
    timer2Async <= 1'h1;
    go_sleep(3'h1, 1'h1);
    chk({ioClkEn, adcClkEn, asyClkEn}, 16'h3);
    @(posedge clock) irqRaise <= 1'h1;
    @(posedge clock) irqRaise <= 1'h0;
    repeat (4) @(posedge clock);
    #1;
    chk(asleep, 1'h1);
    @(posedge clock) wakeAdcDone <= 1'h1;
    wait_wake;
    chk({n, takeIrq}, 16'h9);
    @(posedge clock) {wakeAdcDone, extIrqIsLevel} <= 2'h1;
    $display("test noise done");
    bo_write(1'h1);
    go_sleep(3'h2, 1'h1);
    chk({oscEn, brownoutEn, asleep}, 16'h1);
    @(posedge clock) {wakeAdcDone, wakeStoreReady} <= 2'h3;
    repeat (4) @(posedge clock);
    #1;
    chk(asleep, 1'h1);
    @(posedge clock) {wakeAdcDone, wakeStoreReady, irqRaise} <= 3'h1;
    @(posedge clock) irqRaise <= 1'h0;
    wait_wake;
    chk({n, takeIrq, brownoutEn}, 16'h53);
    $display("test power-down done");
    bo_write(1'h0);
    xtalSelected <= 1'h1;
    go_sleep(3'h6, 1'h1);
    chk({oscEn, asleep}, 16'h3);
    @(posedge clock) sleepResetReq <= 1'h1;
    wait_wake;
    chk({n, resetVector, takeIrq}, 16'h1a);
    @(posedge clock) sleepResetReq <= 1'h0;
    $display("test standby reset done");
    go_sleep(3'h3, 1'h1);
    chk({asyClkEn, timerOscEn, oscEn, flashClkEn}, 16'hc);
    @(posedge clock) wakeTimer2 <= 1'h1;
    wait_wake;
    chk({n, takeIrq}, 16'h1d);
    @(posedge clock) wakeTimer2 <= 1'h0;
    $display("test power-save done");
    go_sleep(3'h7, 1'h1);
    chk({oscEn, asyClkEn, timerOscEn}, 16'h7);
    @(posedge clock) wakeTwoWireMatch <= 1'h1;
    @(posedge clock) wakeTwoWireMatch <= 1'h0;
    #1;
    wait_wake;
    chk({n, takeIrq}, 16'hc);
    $display("test extended standby done");
    complete_run;
  end
endmodule // testbench
